// ===== pkg/uebm_mem_if.sv
// Bank memory port between the bank manager and its storage.
// Assumes one write and one registered read per cycle.
`timescale 1ns/1ps
`default_nettype none
interface uebm_mem_if #(parameter int AW = 7, parameter int DW = 8);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface
`default_nettype wire

// ===== pkg/uebm_pkg.sv
// Constants shared by the endpoint bank manager.
// Assumes a byte-wide register port and two banks per endpoint.
package uebm_pkg;
  localparam int REG_AW         = 3;
  localparam int REG_DW         = 8;
  localparam int NUM_BANKS      = 2;
  localparam int BANK_DEPTH_DEF = 64;
  // Register addresses.
  localparam logic [REG_AW-1:0] ADDR_CFG   = 3'h0;
  localparam logic [REG_AW-1:0] ADDR_FLAGS = 3'h1;
  localparam logic [REG_AW-1:0] ADDR_IEN   = 3'h2;
  localparam logic [REG_AW-1:0] ADDR_COUNT = 3'h3;
  localparam logic [REG_AW-1:0] ADDR_DATA  = 3'h4;
  // Configuration bits.
  localparam int CFG_DIR_IN = 0;
  localparam int CFG_AUTO   = 1;
  localparam int CFG_DMA    = 2;
  localparam int CFG_DUAL   = 3;
  // Flag bits.
  localparam int FLG_ORX  = 0;
  localparam int FLG_INR  = 1;
  localparam int FLG_BCB  = 2;
  localparam int FLG_BANK_ACCESS_ALLOWED = 3;
  localparam int FLG_ZLS  = 4;
  localparam int FLG_KILL = 5;
  // Interrupt enable bits.
  localparam int IEN_ORX = 0;
  localparam int IEN_INR = 1;
  localparam logic [REG_DW-1:0] CFG_RESET = 8'h00;
  localparam logic [REG_DW-1:0] IEN_RESET = 8'h00;
endpackage

// ===== rtl/uebm_bank_store.sv
// Byte storage for all banks of the endpoint.
// Assumes the controller never reads and writes one byte in one cycle.
`timescale 1ns/1ps
`default_nettype none
module uebm_bank_store #(
  parameter int AW = 7,
  parameter int DW = 8
)(
  input wire logic clk_sys,
  input wire logic nrst,
  uebm_mem_if.mem  mem
);
  logic [DW-1:0] ram [2**AW];
  logic [DW-1:0] q_reg;

  always_ff @(posedge clk_sys) begin
    if (mem.wr_en) begin
      ram[mem.wr_addr] <= mem.wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q_reg <= '0;
    end else if (mem.rd_en) begin
      q_reg <= ram[mem.rd_addr];
    end
  end

  assign mem.rd_data = q_reg;
endmodule // uebm_bank_store
`default_nettype wire

// ===== rtl/uebm_reg_read.sv
// Read side of the register port: one cycle read latency.
// Assumes memory data arrive in the cycle after a data port read.
`timescale 1ns/1ps
`default_nettype none
module uebm_reg_read import uebm_pkg::*; (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              rd,
  input  wire logic [REG_AW-1:0] addr,
  input  wire logic [REG_DW-1:0] cfg_val,
  input  wire logic [REG_DW-1:0] flags_val,
  input  wire logic [REG_DW-1:0] ien_val,
  input  wire logic [REG_DW-1:0] count_val,
  input  wire logic [REG_DW-1:0] mem_q,
  output logic      [REG_DW-1:0] rdata
);
  logic              data_sel_reg;
  logic [REG_DW-1:0] val_reg;
  logic [REG_DW-1:0] val_next;

  always_comb begin
    case (addr)
      ADDR_CFG:   val_next = cfg_val;
      ADDR_FLAGS: val_next = flags_val;
      ADDR_IEN:   val_next = ien_val;
      ADDR_COUNT: val_next = count_val;
      default:    val_next = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      val_reg      <= '0;
      data_sel_reg <= 1'b0;
    end else begin
      val_reg      <= rd ? val_next : '0;
      data_sel_reg <= rd && (addr == ADDR_DATA);
    end
  end

  assign rdata = data_sel_reg ? mem_q : val_reg;
endmodule // uebm_reg_read
`default_nettype wire

// ===== rtl/uebm_top.sv
// Endpoint bank manager: one endpoint, OUT or IN, one or two banks.
// Assumes a host-side packet engine and an optional DMA on the bank side.
//
// Overview of operation
// R1 - Full OUT bank sets out flag, control bit
// R2 - Out flag interrupts only when enabled
// R3 - Clearing control bit frees bank, advances
// R4 - Software clears out flag before control bit
// R5 - Access bit set while unread OUT data
// R6 - Auto mode: hardware clears control when emptied
// R7 - Out flag only ever cleared by software
// R8 - Byte count shows bytes in OUT bank
// R9 - Next full bank re-raises out flag at once
// R10 - Auto CPU mode: last read frees bank
// R11 - Auto DMA OUT frees emptied banks
// R12 - DMA auto OUT filters ZLP, sets seen flag
// R13 - DMA manual OUT: software frees each bank
// R14 - Free IN bank sets ready flag, control
// R15 - Clearing IN control sends bank, advances
// R16 - Software clears ready flag before control bit
// R17 - Access bit set while IN bank accepts
// R18 - Auto IN: hardware releases full bank
// R19 - Next free IN bank re-raises ready at once
// R20 - Auto DMA IN releases filled banks
// R21 - DMA manual IN: software releases each bank
// R22 - Kill command discards last written IN bank
`timescale 1ns/1ps
`default_nettype none
module uebm_top import uebm_pkg::*; #(
  parameter int BANK_DEPTH = BANK_DEPTH_DEF
)(
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [REG_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [REG_DW-1:0] reg_rdata,
  output logic                   endpoint_irq,
  output logic                   host_out_ready,
  input  wire logic              host_wr_valid,
  input  wire logic [7:0]        host_wr_data,
  input  wire logic              host_eop,
  output logic                   host_in_avail,
  output logic      [7:0]        host_in_count,
  input  wire logic              host_rd_req,
  output logic      [7:0]        host_rd_data,
  output logic                   host_rd_valid,
  input  wire logic              host_in_ack,
  input  wire logic              dma_rd_req,
  output logic      [7:0]        dma_rd_data,
  output logic                   dma_rd_valid,
  input  wire logic              dma_wr_req,
  input  wire logic [7:0]        dma_wr_data,
  output logic                   dma_req_ready,
  input  wire logic              dma_eot
);
  localparam int AW = $clog2(BANK_DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(BANK_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic              dir_in_reg;
  logic              auto_reg;
  logic              dma_reg;
  logic              dual_reg;
  logic              oie_reg;
  logic              iie_reg;
  logic              orx_reg;
  logic              inr_reg;
  logic              bcb_reg;
  logic              zls_reg;
  logic              ann_reg;
  logic              eot_reg;
  logic              cpu_bank_reg;
  logic              usb_bank_reg;
  logic [CW-1:0]     rptr_reg;
  logic [CW-1:0]     hptr_reg;
  logic              dma_rd_valid_reg;
  logic              host_rd_valid_reg;
  logic              full_reg [NUM_BANKS];
  logic [CW-1:0]     cnt_reg  [NUM_BANKS];

  logic              wr_cfg;
  logic              wr_ien;
  logic              wr_flags;
  logic              clr_orx;
  logic              clr_inr;
  logic              clr_zls;
  logic              kill;
  logic              kill_bank;
  logic              sw_bcb_clr;
  logic              allow_sw;
  logic              cur_full;
  logic [CW-1:0]     cur_cnt;
  logic              usb_full;
  logic [CW-1:0]     usb_cnt;
  logic              bank_access_allowed;
  logic              ready_now;
  logic              announce;
  logic              auto_free;
  logic              switch_bank;
  logic              nxt_cpu;
  logic              nxt_usb;
  logic              cpu_pop;
  logic              cpu_push;
  logic              host_wr_ok;
  logic              zlp_filt;
  logic              eop_take;
  logic              eop_fill;
  logic              in_rd;
  logic              in_ack;
  logic [REG_DW-1:0] flags_val;

  uebm_mem_if #(.AW(AW + 1), .DW(8)) mem ();

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and decoded strobes.

  assign wr_cfg     = reg_wr && (reg_addr == ADDR_CFG);
  assign wr_ien     = reg_wr && (reg_addr == ADDR_IEN);
  assign wr_flags   = reg_wr && (reg_addr == ADDR_FLAGS);
  assign clr_orx    = wr_flags && !reg_wdata[FLG_ORX];
  assign clr_inr    = wr_flags && !reg_wdata[FLG_INR];
  assign clr_zls    = wr_flags && !reg_wdata[FLG_ZLS];
  assign kill       = wr_flags && reg_wdata[FLG_KILL];
  assign sw_bcb_clr = wr_flags && !reg_wdata[FLG_BCB] && bcb_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dir_in_reg <= CFG_RESET[CFG_DIR_IN];
      auto_reg   <= CFG_RESET[CFG_AUTO];
      dma_reg    <= CFG_RESET[CFG_DMA];
      dual_reg   <= CFG_RESET[CFG_DUAL];
    end else if (wr_cfg) begin
      dir_in_reg <= reg_wdata[CFG_DIR_IN];
      auto_reg   <= reg_wdata[CFG_AUTO];
      dma_reg    <= reg_wdata[CFG_DMA];
      dual_reg   <= reg_wdata[CFG_DUAL];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      oie_reg <= IEN_RESET[IEN_ORX];
      iie_reg <= IEN_RESET[IEN_INR];
    end else if (wr_ien) begin
      oie_reg <= reg_wdata[IEN_ORX];
      iie_reg <= reg_wdata[IEN_INR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current bank view and bank switching.

  assign cur_full  = full_reg[cpu_bank_reg];
  assign cur_cnt   = cnt_reg[cpu_bank_reg];
  assign usb_full  = full_reg[usb_bank_reg];
  assign usb_cnt   = cnt_reg[usb_bank_reg];
  assign nxt_cpu   = dual_reg ? ~cpu_bank_reg : cpu_bank_reg;
  assign nxt_usb   = dual_reg ? ~usb_bank_reg : usb_bank_reg;
  assign kill_bank = dual_reg ? ~cpu_bank_reg : cpu_bank_reg;

  // An OUT bank is ready once full; an IN bank once free.
  assign ready_now = dir_in_reg ? !cur_full : cur_full;
  assign announce  = ready_now && !ann_reg; // R9 R19

  always_comb begin
    if (dir_in_reg) begin
      bank_access_allowed = !cur_full && (cur_cnt < DEPTH_C); // R17
    end else begin
      bank_access_allowed = cur_full && (rptr_reg < cur_cnt); // R5
    end
  end

  // In auto mode a software clear counts only after the DMA ended early.
  assign allow_sw = !auto_reg || (dma_reg && eot_reg); // R10 R11 R18 R20

  always_comb begin
    if (!auto_reg || !ann_reg) begin
      auto_free = 1'b0;
    end else if (dir_in_reg) begin
      auto_free = !cur_full && (cur_cnt == DEPTH_C); // R18 R20
    end else begin
      auto_free = cur_full && (rptr_reg == cur_cnt); // R6 R10 R11
    end
  end

  assign switch_bank = (sw_bcb_clr && allow_sw) || auto_free; // R3 R15

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cpu_bank_reg <= 1'b0;
    end else if (switch_bank) begin
      cpu_bank_reg <= nxt_cpu; // R3 R15
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ann_reg <= 1'b0;
    end else if (switch_bank) begin
      ann_reg <= 1'b0;
    end else if (announce) begin
      ann_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bcb_reg <= 1'b0;
    end else if (switch_bank) begin
      bcb_reg <= 1'b0; // R6 R18
    end else if (announce) begin
      bcb_reg <= 1'b1; // R1 R14
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      eot_reg <= 1'b0;
    end else if (dma_eot) begin
      eot_reg <= 1'b1; // R11 R20
    end else if (switch_bank) begin
      eot_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags; a hardware set wins over a software clear.

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      orx_reg <= 1'b0;
    end else if (announce && !dir_in_reg) begin
      orx_reg <= 1'b1; // R1 R9
    end else if (clr_orx) begin
      orx_reg <= 1'b0; // R7
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      inr_reg <= 1'b0;
    end else if (announce && dir_in_reg) begin
      inr_reg <= 1'b1; // R14 R19
    end else if (clr_inr) begin
      inr_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      zls_reg <= 1'b0;
    end else if (eop_take && zlp_filt) begin
      zls_reg <= 1'b1; // R12
    end else if (clr_zls) begin
      zls_reg <= 1'b0;
    end
  end

  assign endpoint_irq = (orx_reg && oie_reg) || (inr_reg && iie_reg); // R2 R14

  ////////////////////////////////////////////////////////////////////////////
  // Bank side data movement by CPU data port or DMA.

  always_comb begin
    if (dma_reg) begin
      cpu_pop  = !dir_in_reg && bank_access_allowed && dma_rd_req;
      cpu_push = dir_in_reg && bank_access_allowed && dma_wr_req;
    end else begin
      cpu_pop  = !dir_in_reg && bank_access_allowed && reg_rd && (reg_addr == ADDR_DATA); // R8
      cpu_push = dir_in_reg && bank_access_allowed && reg_wr && (reg_addr == ADDR_DATA);
    end
  end

  assign dma_req_ready = dma_reg && bank_access_allowed; // R13 R21

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rptr_reg <= '0;
    end else if (switch_bank) begin
      rptr_reg <= '0;
    end else if (cpu_pop) begin
      rptr_reg <= rptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dma_rd_valid_reg <= 1'b0;
    end else begin
      dma_rd_valid_reg <= cpu_pop && dma_reg;
    end
  end

  assign dma_rd_valid = dma_rd_valid_reg;
  assign dma_rd_data  = mem.rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // Host side of the banks.

  assign host_out_ready = !dir_in_reg && !usb_full;
  assign host_wr_ok     = host_wr_valid && host_out_ready && (usb_cnt < DEPTH_C);
  assign zlp_filt       = dma_reg && auto_reg && (usb_cnt == '0);
  assign eop_take       = host_eop && host_out_ready;
  assign eop_fill       = eop_take && !zlp_filt; // R12
  assign host_in_avail  = dir_in_reg && usb_full;
  assign host_in_count  = 8'(usb_cnt);
  assign in_rd          = host_rd_req && host_in_avail && (hptr_reg < usb_cnt);
  assign in_ack         = host_in_ack && host_in_avail;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      usb_bank_reg <= 1'b0;
    end else if (eop_fill || in_ack) begin
      usb_bank_reg <= nxt_usb;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hptr_reg <= '0;
    end else if (in_ack || kill) begin
      hptr_reg <= '0;
    end else if (in_rd) begin
      hptr_reg <= hptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      host_rd_valid_reg <= 1'b0;
    end else begin
      host_rd_valid_reg <= in_rd;
    end
  end

  assign host_rd_valid = host_rd_valid_reg;
  assign host_rd_data  = mem.rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // Per-bank fill state.

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic at_cpu;
    logic at_usb;
    logic kill_b;
    assign at_cpu = (cpu_bank_reg == 1'(b));
    assign at_usb = (usb_bank_reg == 1'(b));
    assign kill_b = kill && dir_in_reg && full_reg[b] && (kill_bank == 1'(b)); // R22

    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        full_reg[b] <= 1'b0;
      end else if (kill_b) begin
        full_reg[b] <= 1'b0; // R22
      end else if (switch_bank && at_cpu) begin
        full_reg[b] <= dir_in_reg; // R3 R15
      end else if (eop_fill && at_usb) begin
        full_reg[b] <= 1'b1; // R1
      end else if (in_ack && at_usb) begin
        full_reg[b] <= 1'b0;
      end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        cnt_reg[b] <= '0;
      end else if (kill_b || (in_ack && at_usb)) begin
        cnt_reg[b] <= '0;
      end else if (switch_bank && at_cpu && !dir_in_reg) begin
        cnt_reg[b] <= '0;
      end else if ((host_wr_ok && at_usb) || (cpu_push && at_cpu)) begin
        cnt_reg[b] <= cnt_reg[b] + 1'b1; // R8
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank memory and register read-back.

  assign mem.wr_en   = host_wr_ok || cpu_push;
  assign mem.wr_data = host_wr_ok ? host_wr_data : (dma_reg ? dma_wr_data : reg_wdata);
  assign mem.wr_addr = host_wr_ok ? {usb_bank_reg, usb_cnt[AW-1:0]}
                                  : {cpu_bank_reg, cur_cnt[AW-1:0]};
  assign mem.rd_en   = cpu_pop || in_rd;
  assign mem.rd_addr = cpu_pop ? {cpu_bank_reg, rptr_reg[AW-1:0]}
                               : {usb_bank_reg, hptr_reg[AW-1:0]};

  uebm_bank_store #(.AW(AW + 1), .DW(8)) u_store (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .mem     (mem.mem)
  );

  assign flags_val = {3'h0, zls_reg, bank_access_allowed, bcb_reg, inr_reg, orx_reg};

  uebm_reg_read u_read (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .rd        (reg_rd),
    .addr      (reg_addr),
    .cfg_val   ({4'h0, dual_reg, dma_reg, auto_reg, dir_in_reg}),
    .flags_val (flags_val),
    .ien_val   ({6'h00, iie_reg, oie_reg}),
    .count_val (REG_DW'(cur_cnt)),
    .mem_q     (mem.rd_data),
    .rdata     (reg_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_out_flag_set: assert property ( // R1
    announce && !dir_in_reg |=> orx_reg && bcb_reg)
    else $error("out bank ready did not raise flag and control bit");

  a_irq_gated: assert property ( // R2
    !oie_reg && !inr_reg |-> !endpoint_irq)
    else $error("interrupt raised with enable low");

  a_sw_switch: assert property ( // R3
    sw_bcb_clr && !auto_reg && dual_reg && !wr_cfg |=> cpu_bank_reg != $past(cpu_bank_reg))
    else $error("software clear did not advance bank");

  a_bank_access_allowed_out: assert property ( // R5
    !dir_in_reg && cur_full && rptr_reg == cur_cnt |-> !bank_access_allowed)
    else $error("access bit set on empty out bank");

  a_auto_empty: assert property ( // R6
    !dir_in_reg && auto_reg && ann_reg && cur_full && rptr_reg == cur_cnt
    && !wr_cfg |=> !bcb_reg)
    else $error("auto mode did not clear control bit");

  a_count_read: assert property ( // R8
    reg_rd && reg_addr == ADDR_COUNT |=> reg_rdata == REG_DW'($past(cur_cnt)))
    else $error("byte count read mismatch");

  a_auto_noeffect: assert property ( // R10
    auto_reg && !eot_reg && sw_bcb_clr && !auto_free && !wr_cfg |=> bcb_reg)
    else $error("software clear acted in auto mode");

  a_zero_length_seen_flag: assert property ( // R12
    eop_take && zlp_filt && !wr_cfg |=> zls_reg && !host_in_avail)
    else $error("filtered zero length packet not flagged");

  a_in_flag_set: assert property ( // R14
    announce && dir_in_reg |=> inr_reg && bcb_reg)
    else $error("free in bank did not raise ready flag");

  a_in_release: assert property ( // R15
    switch_bank && dir_in_reg && !kill && !wr_cfg && cpu_bank_reg |=> full_reg[1])
    else $error("released in bank not handed to host");

  a_bank_access_allowed_in: assert property ( // R17
    dir_in_reg && cur_cnt == DEPTH_C |-> !bank_access_allowed)
    else $error("access bit set on full in bank");

  a_kill_bank: assert property ( // R22
    g_bank[1].kill_b |=> !full_reg[1] ##0 cnt_reg[1] == '0)
    else $error("killed bank not discarded");

  c_out_ready: cover property (announce && !dir_in_reg ##1 orx_reg);
  c_in_switch: cover property (switch_bank && dir_in_reg && dual_reg);
  c_zero_length_seen_flag:  cover property (eop_take && zlp_filt);
  c_kill:      cover property (kill && dir_in_reg && dual_reg);
endmodule // uebm_top
`default_nettype wire

// ===== sim/uebm_host_model.sv
// Host side stand-in: sends OUT packets and fetches IN packets.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module uebm_host_model (
  input  wire logic       clk_sys,
  output logic            wr_valid,
  output logic [7:0]      wr_data,
  output logic            eop,
  output logic            rd_req,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic            in_ack
);
  int         sent[$];
  logic [7:0] got[$];
  initial begin
    {wr_valid, wr_data, eop, rd_req, in_ack} = '0;
  end
  task automatic send(input int n);
    int b;
    for (int i = 0; i < n; i++) begin
      b = $urandom_range(255, 0);
      sent.push_back(b);
      wr_valid <= 1'b1;
      wr_data  <= b[7:0];
      @(posedge clk_sys);
    end
    // Released data lines show the inverse of the last byte, not a stale copy.
    wr_valid <= 1'b0;
    wr_data  <= ~wr_data;
    eop      <= 1'b1;
    @(posedge clk_sys);
    eop <= 1'b0;
  endtask
  task automatic fetch(input int n);
    for (int i = 0; i < n; i++) begin
      rd_req <= 1'b1;
      @(posedge clk_sys);
      rd_req <= 1'b0;
      @(posedge clk_sys);
      if (rd_valid === 1'b1) got.push_back(rd_data);
    end
    in_ack <= 1'b1;
    @(posedge clk_sys);
    in_ack <= 1'b0;
  endtask
endmodule // uebm_host_model
`default_nettype wire

// ===== sim/usb_endpoint_bank_manager_tb.sv
// Self-checking bench for the endpoint bank manager, four-byte banks.
// Assumes the host stand-in model and the register map of the package.
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_bank_manager_tb import uebm_pkg::*; ();
  logic              clk_sys = 1'b0;
  logic              nrst, reg_wr, reg_rd, endpoint_irq, host_out_ready;
  logic [REG_AW-1:0] reg_addr;
  logic [7:0]        reg_wdata, reg_rdata, host_wr_data, host_in_count, host_rd_data;
  logic              host_wr_valid, host_eop, host_in_avail, host_rd_req;
  logic              host_rd_valid, host_in_ack;
  logic              dma_rd_req, dma_wr_req, dma_rd_valid, dma_req_ready;
  logic [7:0]        dma_rd_data, dma_wr_data;
  int                fail_count, total_checks, cyc;
  logic [7:0]        q[$];
  int                pk[$];
  uebm_top #(.BANK_DEPTH(4)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .endpoint_irq(endpoint_irq), .host_out_ready(host_out_ready),
    .host_wr_valid(host_wr_valid), .host_wr_data(host_wr_data), .host_eop(host_eop),
    .host_in_avail(host_in_avail), .host_in_count(host_in_count),
    .host_rd_req(host_rd_req), .host_rd_data(host_rd_data), .host_rd_valid(host_rd_valid),
    .host_in_ack(host_in_ack), .dma_rd_req(dma_rd_req), .dma_rd_data(dma_rd_data),
    .dma_rd_valid(dma_rd_valid), .dma_wr_req(dma_wr_req), .dma_wr_data(dma_wr_data),
    .dma_req_ready(dma_req_ready), .dma_eot(1'b0));
  uebm_host_model i_host (.clk_sys(clk_sys), .wr_valid(host_wr_valid),
    .wr_data(host_wr_data), .eop(host_eop), .rd_req(host_rd_req), .rd_data(host_rd_data),
    .rd_valid(host_rd_valid), .in_ack(host_in_ack));
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [REG_AW-1:0] a, input logic [7:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [REG_AW-1:0] a, output logic [7:0] d);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    logic [7:0] d;
    for (int i = 0; i < 40; i++) begin
      rd(ADDR_FLAGS, d);
      if ((d & m) === v) break;
    end
    chk(d & m, v);
  endtask
  task automatic drain_out();
    logic [7:0] d;
    int         n, e;
    n = pk.pop_front();
    rd(ADDR_COUNT, d);
    chk(d, n[7:0]);
    repeat (n) begin
      rd(ADDR_DATA, d);
      e = i_host.sent.pop_front();
      chk(d, e[7:0]);
    end
  endtask
  task automatic fill();
    int b;
    repeat (4) begin
      b = $urandom_range(255, 0);
      q.push_back(b[7:0]);
      wr(ADDR_DATA, b[7:0]);
    end
  endtask
  task automatic take();
    for (int i = 0; i < 20 && host_in_avail !== 1'b1; i++) @(posedge clk_sys);
    chk(host_in_count, 8'h04);
    i_host.fetch(4);
    repeat (4) chk(i_host.got.pop_front(), q.pop_front());
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    int         n, e;
    {nrst, reg_wr, reg_rd, dma_rd_req, dma_wr_req} = '0;
    dma_wr_data = '0;
    reg_addr  = '0;
    reg_wdata = '0;
    void'($urandom(72393));
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(ADDR_CFG, d);
    chk(d, CFG_RESET);
    poll(8'hff, 8'h00);
    chk({7'h00, host_out_ready}, 8'h01);
    n = $urandom_range(4, 1);
    pk.push_back(n);
    i_host.send(n);
    poll(8'h0d, 8'h0d);
    chk({7'h00, endpoint_irq}, 8'h00);
    wr(ADDR_IEN, 8'h01);
    chk({7'h00, endpoint_irq}, 8'h01);
    drain_out();
    poll(8'h0d, 8'h05);
    wr(ADDR_FLAGS, 8'hde);
    chk({7'h00, endpoint_irq}, 8'h00);
    wr(ADDR_FLAGS, 8'hda);
    poll(8'h0d, 8'h00);
    chk({7'h00, host_out_ready}, 8'h01);
    // Two banks with automatic release: the host fills both before the CPU reads.
    wr(ADDR_CFG, 8'h0a);
    repeat (2) begin
      n = $urandom_range(4, 1);
      pk.push_back(n);
      i_host.send(n);
    end
    poll(8'h05, 8'h05);
    wr(ADDR_FLAGS, 8'hda);
    poll(8'h05, 8'h04);
    drain_out();
    poll(8'h05, 8'h05);
    drain_out();
    poll(8'h0d, 8'h01);
    wr(ADDR_FLAGS, 8'hde);
    wr(ADDR_CFG, 8'h06);
    i_host.send(0);
    poll(8'h10, 8'h10);
    wr(ADDR_FLAGS, 8'hcf);
    // Two banks, DMA without automatic release: software frees each bank.
    wr(ADDR_CFG, 8'h0c);
    n = $urandom_range(4, 1);
    i_host.send(n);
    poll(8'h0d, 8'h0d);
    wr(ADDR_FLAGS, 8'hde);
    chk({7'h00, dma_req_ready}, 8'h01);
    repeat (n) begin
      e = i_host.sent.pop_front();
      dma_rd_req <= 1'b1;
      @(posedge clk_sys);
      dma_rd_req <= 1'b0;
      @(negedge clk_sys);
      chk({7'h00, dma_rd_valid}, 8'h01);
      chk(dma_rd_data, e[7:0]);
      @(posedge clk_sys);
    end
    poll(8'h08, 8'h00);
    chk({7'h00, dma_req_ready}, 8'h00);
    wr(ADDR_FLAGS, 8'hda);
    poll(8'h0d, 8'h00);
    // IN direction: fill, hand over, kill, refill, then hand the bank to the host.
    wr(ADDR_CFG, 8'h01);
    wr(ADDR_IEN, 8'h02);
    poll(8'h0e, 8'h0e);
    chk({7'h00, endpoint_irq}, 8'h01);
    fill();
    poll(8'h08, 8'h00);
    wr(ADDR_FLAGS, 8'hdd);
    chk({7'h00, endpoint_irq}, 8'h00);
    wr(ADDR_FLAGS, 8'hd9);
    chk({7'h00, host_in_avail}, 8'h01);
    wr(ADDR_FLAGS, 8'hff);
    chk({7'h00, host_in_avail}, 8'h00);
    poll(8'h0e, 8'h0e);
    q.delete();
    fill();
    wr(ADDR_FLAGS, 8'hdd);
    wr(ADDR_FLAGS, 8'hd9);
    take();
    poll(8'h06, 8'h06);
    wr(ADDR_CFG, 8'h03);
    fill();
    take();
    poll(8'h06, 8'h06);
    // DMA fills the IN bank; software releases it by hand.
    wr(ADDR_CFG, 8'h05);
    chk({7'h00, dma_req_ready}, 8'h01);
    repeat (4) begin
      n = $urandom_range(255, 0);
      q.push_back(n[7:0]);
      dma_wr_req  <= 1'b1;
      dma_wr_data <= n[7:0];
      @(posedge clk_sys);
      dma_wr_req <= 1'b0;
      @(posedge clk_sys);
    end
    wr(ADDR_FLAGS, 8'hdd);
    poll(8'h08, 8'h00);
    chk({7'h00, dma_req_ready}, 8'h00);
    wr(ADDR_FLAGS, 8'hd9);
    take();
    report_and_stop();
  end
endmodule // usb_endpoint_bank_manager_tb
`default_nettype wire
